// *** core/adc_config_and_test_patterns.sv ***
// Purpose: Control register bank, serial port and test-pattern generator.
// Assumes: All pins synchronous to clk_i; serial clock sampled as data.
// Notes:   A two-entry buffer sits between pattern mux and link transport.
//
// Contract
// - Divider code 00/10 bypass, 01 divide by two, 11 divide by four.
// - Three-bit frame reference delay code, 60 ps per step, to 420 ps.
// - Bit 7 powers down first channel, bit 6 the second channel.
// - Standby powers down both converters, clock and line drivers stay on.
// - Format bit clear gives two's complement, set gives offset binary.
// - Soft reset bit restores all registers to defaults and self-clears.
// - Gain code acts only while its enable bit is set.
// - Gain codes 00011 to 10011 give -2 dB to 6 dB in half steps.
// - Overrange select routes normal or quick overrange to both outputs.
// - Per-channel pattern select replaces samples; two low bits forced 00.
// - Codes pass samples, zeros, ones, or alternating bit toggle pattern.
// - Ramp rises by one every fourth step from 0 to 16383, wraps.
// - Single custom pattern, or alternating custom patterns one and two.
// - Deskew code outputs word AAA8h on every sample.
// - Pseudo-random code outputs a pseudo-random sequence.
// - Sine code repeats eight fixed offset binary values.
// - Custom pattern bytes at addresses 10, 11, 12, shared by channels.
// - Custom pattern two low byte at 13, shared, default zero.
// - Bits shift on serial clock rise while select low; commit on 16th.
// - Word is read flag, zero bit, six address bits, eight data bits.
// - Read data driven on falling serial edges; output off during writes.
`include "adc_cfg_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module adc_config_and_test_patterns #(
  parameter int unsigned BUF_DEPTH = 2
) (
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       serial_clk_i,
  input  wire logic                       serial_select_n_i,
  input  wire logic                       serial_port_in_i,
  output logic                            serial_port_out_o,
  output logic                            serial_port_out_oe_o,
  input  wire logic                       sample_valid_i,
  output logic                            sample_ready_o,
  input  wire adc_cfg_pkg::sample_pair_t  sample_i,
  output logic                            link_valid_o,
  input  wire logic                       link_ready_i,
  output adc_cfg_pkg::link_word_t         link_word_o,
  input  wire adc_cfg_pkg::ovr_pair_t     normal_ovr_i,
  input  wire adc_cfg_pkg::ovr_pair_t     quick_ovr_i,
  output logic                            first_channel_overrange_out_o,
  output logic                            second_channel_overrange_out_o,
  output logic [1:0]                      sample_clk_div_log2_o,
  output logic [2:0]                      frame_ref_delay_o,
  output logic                            power_down_first_channel_o,
  output logic                            power_down_second_channel_o,
  output logic                            converters_standby_o,
  output logic [1:0]                      high_input_mode_first_o,
  output logic [1:0]                      high_input_mode_second_o
);
  import adc_cfg_pkg::*;

  localparam int unsigned PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(BUF_DEPTH + 1);

  if (BUF_DEPTH < 2) begin : g_depth_check
    $error("BUF_DEPTH must be at least 2");
  end

  // Configuration registers.
  logic [7:0] clk_div_ff;
  logic [7:0] ref_delay_ff;
  logic [7:0] pwr_fmt_ff;
  logic [7:0] gain_a_ff;
  logic [7:0] gain_b_ff;
  logic [7:0] hf_first_ff;
  logic [7:0] hf_second_ff;
  logic [7:0] pattern_sel_ff;
  logic [7:0] cust1_hi_ff;
  logic [7:0] cust1_lo_ff;
  logic [7:0] cust2_hi_ff;
  logic [7:0] cust2_lo_ff;
  logic       soft_rst_ff;

  // Serial port state.
  logic        sclk_q_ff;
  logic [3:0]  bit_cnt_ff;
  logic [14:0] shift_ff;
  logic [7:0]  rd_shift_ff;
  logic        rd_phase_ff;
  logic        sout_ff;

  logic        sclk_rise;
  logic        sclk_fall;
  logic [15:0] ser_word;
  logic        commit;
  logic        wr_ok;
  logic [5:0]  rd_addr;

  assign sclk_rise = serial_clk_i & ~sclk_q_ff;
  assign sclk_fall = ~serial_clk_i & sclk_q_ff;
  assign ser_word  = {shift_ff, serial_port_in_i};
  assign commit    = sclk_rise & ~serial_select_n_i
                     & (bit_cnt_ff == 4'hF);
  assign wr_ok     = commit & ~ser_word[`SER_READ_BIT]
                     & ~ser_word[`SER_ZERO_BIT];
  assign rd_addr   = {shift_ff[4:0], serial_port_in_i};

  function automatic logic [7:0] read_reg(input logic [5:0] addr);
    unique case (addr)
      `OFS_CLK_DIV:     read_reg = clk_div_ff;
      `OFS_REF_DELAY:   read_reg = ref_delay_ff;
      `OFS_PWR_FMT:     read_reg = pwr_fmt_ff;
      `OFS_GAIN_A:      read_reg = gain_a_ff;
      `OFS_GAIN_B:      read_reg = gain_b_ff;
      `OFS_HF_FIRST:    read_reg = hf_first_ff;
      `OFS_HF_SECOND:   read_reg = hf_second_ff;
      `OFS_PATTERN_SEL: read_reg = pattern_sel_ff;
      `OFS_CUST1_HI:    read_reg = cust1_hi_ff;
      `OFS_CUST1_LO:    read_reg = cust1_lo_ff;
      `OFS_CUST2_HI:    read_reg = cust2_hi_ff;
      `OFS_CUST2_LO:    read_reg = cust2_lo_ff;
      default:          read_reg = 8'h00;
    endcase
  endfunction

  // Excess bits past a 16-bit boundary simply start a new word that never
  // completes, so they are dropped when the select pin rises.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_q_ff  <= 1'b0;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 15'h0000;
    end else begin
      sclk_q_ff <= serial_clk_i;
      if (serial_select_n_i) begin
        bit_cnt_ff <= 4'h0;
      end else if (sclk_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        shift_ff   <= ser_word[14:0];
      end
    end
  end

  // The read byte is captured at the eighth rising edge, when the address
  // is complete, and shifted out MSB first on the following falling edges.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_shift_ff <= 8'h00;
      rd_phase_ff <= 1'b0;
      sout_ff     <= 1'b0;
    end else begin
      if (serial_select_n_i || commit) begin
        rd_phase_ff <= 1'b0;
      end else if (sclk_rise && bit_cnt_ff == 4'h7) begin
        rd_phase_ff <= shift_ff[6] & ~shift_ff[5];
        rd_shift_ff <= read_reg(rd_addr);
      end else if (sclk_fall && rd_phase_ff) begin
        sout_ff     <= rd_shift_ff[7];
        rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
      end
    end
  end

  assign serial_port_out_o    = sout_ff;
  assign serial_port_out_oe_o = rd_phase_ff & ~serial_select_n_i;

  // Soft reset takes one cycle: the commit raises the pulse and the next
  // edge returns every register to its default. The bit is never stored.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= wr_ok && ser_word[13:8] == `OFS_PWR_FMT
                     && ser_word[`BIT_SOFT_RESET];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {clk_div_ff, ref_delay_ff, pwr_fmt_ff, gain_a_ff, gain_b_ff,
       hf_first_ff, hf_second_ff, pattern_sel_ff, cust1_hi_ff, cust1_lo_ff,
       cust2_hi_ff, cust2_lo_ff} <= {12{`RST_BYTE}};
    end else if (soft_rst_ff) begin
      {clk_div_ff, ref_delay_ff, pwr_fmt_ff, gain_a_ff, gain_b_ff,
       hf_first_ff, hf_second_ff, pattern_sel_ff, cust1_hi_ff, cust1_lo_ff,
       cust2_hi_ff, cust2_lo_ff} <= {12{`RST_BYTE}};
    end else if (wr_ok) begin
      unique case (ser_word[13:8])
        `OFS_CLK_DIV:     clk_div_ff     <= ser_word[7:0] & `MASK_CLK_DIV;
        `OFS_REF_DELAY:   ref_delay_ff   <= ser_word[7:0] & `MASK_REF_DELAY;
        `OFS_PWR_FMT:     pwr_fmt_ff     <= ser_word[7:0] & `MASK_PWR_FMT;
        `OFS_GAIN_A:      gain_a_ff      <= ser_word[7:0] & `MASK_GAIN;
        `OFS_GAIN_B:      gain_b_ff      <= ser_word[7:0] & `MASK_GAIN;
        `OFS_HF_FIRST:    hf_first_ff    <= ser_word[7:0] & `MASK_HF_FIRST;
        `OFS_HF_SECOND:   hf_second_ff   <= ser_word[7:0] & `MASK_HF_SECOND;
        `OFS_PATTERN_SEL: pattern_sel_ff <= ser_word[7:0];
        `OFS_CUST1_HI:    cust1_hi_ff    <= ser_word[7:0];
        `OFS_CUST1_LO:    cust1_lo_ff    <= ser_word[7:0];
        `OFS_CUST2_HI:    cust2_hi_ff    <= ser_word[7:0];
        `OFS_CUST2_LO:    cust2_lo_ff    <= ser_word[7:0];
        default: ;
      endcase
    end
  end

  // Analog-facing controls.
  always_comb begin
    unique case (clk_div_ff[1:0])
      2'b01:   sample_clk_div_log2_o = 2'h1;
      2'b11:   sample_clk_div_log2_o = 2'h2;
      default: sample_clk_div_log2_o = 2'h0;
    endcase
  end

  assign frame_ref_delay_o           = ref_delay_ff[2:0];
  assign power_down_first_channel_o  = pwr_fmt_ff[`BIT_PD_FIRST];
  assign power_down_second_channel_o = pwr_fmt_ff[`BIT_PD_SECOND];
  assign converters_standby_o        = pwr_fmt_ff[`BIT_STANDBY];
  assign high_input_mode_first_o     = {hf_first_ff[`BIT_HF_HI],
                                        hf_first_ff[`BIT_HF_LO]};
  assign high_input_mode_second_o    = {hf_second_ff[`BIT_HF_HI],
                                        hf_second_ff[`BIT_HF_LO]};
  assign first_channel_overrange_out_o  = hf_first_ff[`BIT_QUICK_OVR]
      ? quick_ovr_i.first : normal_ovr_i.first;
  assign second_channel_overrange_out_o = hf_first_ff[`BIT_QUICK_OVR]
      ? quick_ovr_i.second : normal_ovr_i.second;

  // Gain multiplier in Q.10; unused codes fall back to unity.
  function automatic logic [11:0] gain_mult(input logic [7:0] reg_val);
    logic [11:0] m;
    m = `GAIN_UNITY;
    if (reg_val[`BIT_GAIN_EN]) begin
      unique case (reg_val[7:3])
        5'h03: m = 12'h32D;
        5'h04: m = 12'h35D;
        5'h05: m = 12'h390;
        5'h06: m = 12'h3C7;
        5'h08: m = 12'h43D;
        5'h09: m = 12'h47D;
        5'h0A: m = 12'h4C1;
        5'h0B: m = 12'h509;
        5'h0C: m = 12'h556;
        5'h0D: m = 12'h5A6;
        5'h0E: m = 12'h5FC;
        5'h0F: m = 12'h657;
        5'h10: m = 12'h6B7;
        5'h11: m = 12'h71E;
        5'h12: m = 12'h78A;
        5'h13: m = 12'h7FB;
        default: m = `GAIN_UNITY;
      endcase
    end
    gain_mult = m;
  endfunction

  // Saturating gain, then output number format.
  function automatic logic [13:0] scale(input logic [13:0] s,
                                        input logic [7:0]  reg_val,
                                        input logic        offset_bin);
    logic signed [26:0] prod;
    logic signed [26:0] shifted;
    logic [13:0]        r;
    prod    = 27'($signed(s)) * 27'($signed({1'b0, gain_mult(reg_val)}));
    shifted = prod >>> `GAIN_FRAC_BITS;
    if (shifted > 27'sd8191) r = 14'h1FFF;
    else if (shifted < -27'sd8192) r = 14'h2000;
    else r = shifted[13:0];
    scale = offset_bin ? {~r[13], r[12:0]} : r;
  endfunction

  // Shared pattern state, advanced once per word pushed into the buffer.
  logic [13:0] ramp_ff;
  logic [1:0]  ramp_pre_ff;
  logic        toggle_ff;
  logic [2:0]  sine_idx_ff;
  logic [14:0] prbs_ff;
  logic        push;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {ramp_ff, ramp_pre_ff, toggle_ff, sine_idx_ff} <= '0;
      prbs_ff <= `PRBS_SEED;
    end else if (soft_rst_ff) begin
      {ramp_ff, ramp_pre_ff, toggle_ff, sine_idx_ff} <= '0;
      prbs_ff <= `PRBS_SEED;
    end else if (push) begin
      ramp_pre_ff <= ramp_pre_ff + 2'h1;
      if (ramp_pre_ff == 2'h3) begin
        ramp_ff <= ramp_ff + 14'h0001;
      end
      toggle_ff   <= ~toggle_ff;
      sine_idx_ff <= sine_idx_ff + 3'h1;
      prbs_ff     <= {prbs_ff[13:0], prbs_ff[14] ^ prbs_ff[13]};
    end
  end

  function automatic logic [13:0] sine_val(input logic [2:0] idx);
    unique case (idx)
      3'h0: sine_val = 14'h0000;
      3'h1: sine_val = 14'h095F;
      3'h2: sine_val = 14'h2000;
      3'h3: sine_val = 14'h36A0;
      3'h4: sine_val = 14'h3FFF;
      3'h5: sine_val = 14'h36A0;
      3'h6: sine_val = 14'h2000;
      3'h7: sine_val = 14'h095F;
    endcase
  endfunction

  // Reserved codes are sent as zero words.
  function automatic logic [15:0] pattern_word(input logic [3:0]  code,
                                               input logic [13:0] normal);
    logic [13:0] d;
    d = 14'h0000;
    unique case (pattern_t'(code))
      PAT_NORMAL: d = normal;
      PAT_ZEROS:  d = 14'h0000;
      PAT_ONES:   d = 14'h3FFF;
      PAT_TOGGLE: d = toggle_ff ? 14'h1555 : 14'h2AAA;
      PAT_RAMP:   d = ramp_ff;
      PAT_SINGLE: d = {cust1_hi_ff, cust1_lo_ff[7:2]};
      PAT_DOUBLE: d = toggle_ff ? {cust2_hi_ff, cust2_lo_ff[7:2]}
                                : {cust1_hi_ff, cust1_lo_ff[7:2]};
      PAT_PRBS:   d = prbs_ff[13:0];
      PAT_SINE:   d = sine_val(sine_idx_ff);
      default:    d = 14'h0000;
    endcase
    pattern_word = (pattern_t'(code) == PAT_DESKEW) ? `DESKEW_WORD
                                                    : {d, 2'b00};
  endfunction

  // Pattern mux feeds the buffer; a powered-down channel sends zeros.
  link_word_t in_word;
  logic       pd_a;
  logic       pd_b;

  assign pd_a = pwr_fmt_ff[`BIT_PD_FIRST] | pwr_fmt_ff[`BIT_STANDBY];
  assign pd_b = pwr_fmt_ff[`BIT_PD_SECOND] | pwr_fmt_ff[`BIT_STANDBY];

  always_comb begin
    in_word.first  = pd_a ? 16'h0000 : pattern_word(pattern_sel_ff[7:4],
        scale(sample_i.first, gain_a_ff, pwr_fmt_ff[`BIT_FORMAT]));
    in_word.second = pd_b ? 16'h0000 : pattern_word(pattern_sel_ff[3:0],
        scale(sample_i.second, gain_b_ff, pwr_fmt_ff[`BIT_FORMAT]));
  end

  // Small buffer: a stall on the link side fills it and then back-pressures
  // the sample source through sample_ready_o.
  link_word_t        buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0]  wr_ptr_ff;
  logic [PTR_W-1:0]  rd_ptr_ff;
  logic [CNT_W-1:0]  count_ff;
  logic              pop;

  assign sample_ready_o = (count_ff != CNT_W'(BUF_DEPTH));
  assign link_valid_o   = (count_ff != '0);
  assign push           = sample_valid_i & sample_ready_o;
  assign pop            = link_valid_o & link_ready_i;
  assign link_word_o    = buf_mem[rd_ptr_ff];

  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
    ptr_next = (p == PTR_W'(BUF_DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) wr_ptr_ff <= ptr_next(wr_ptr_ff);
      if (pop) rd_ptr_ff <= ptr_next(rd_ptr_ff);
      count_ff <= count_ff + CNT_W'(push) - CNT_W'(pop);
    end
  end

  for (genvar gi = 0; gi < BUF_DEPTH; gi++) begin : g_buf
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        buf_mem[gi] <= '0;
      end else if (push && wr_ptr_ff == PTR_W'(gi)) begin
        buf_mem[gi] <= in_word;
      end
    end
  end

endmodule

`default_nettype wire

// *** core/adc_cfg_regs.svh ***
// Purpose: Register offsets, field positions, reset values and constants.
// Assumes: Included by bare name; definitions only.
// Notes:   Offsets are the serial-port register addresses.
`ifndef ADC_CFG_REGS_SVH
`define ADC_CFG_REGS_SVH

`define OFS_CLK_DIV      6'h06
`define OFS_REF_DELAY    6'h07
`define OFS_PWR_FMT      6'h08
`define OFS_GAIN_A       6'h0B
`define OFS_GAIN_B       6'h0C
`define OFS_HF_FIRST     6'h0D
`define OFS_HF_SECOND    6'h0E
`define OFS_PATTERN_SEL  6'h0F
`define OFS_CUST1_HI     6'h10
`define OFS_CUST1_LO     6'h11
`define OFS_CUST2_HI     6'h12
`define OFS_CUST2_LO     6'h13

`define RST_BYTE         8'h00
`define MASK_CLK_DIV     8'h03
`define MASK_REF_DELAY   8'h07
`define MASK_PWR_FMT     8'hF8
`define MASK_GAIN        8'hFC
`define MASK_HF_FIRST    8'h91
`define MASK_HF_SECOND   8'h90

`define BIT_PD_FIRST     7
`define BIT_PD_SECOND    6
`define BIT_STANDBY      5
`define BIT_FORMAT       4
`define BIT_SOFT_RESET   0
`define BIT_GAIN_EN      2
`define BIT_HF_HI        7
`define BIT_HF_LO        4
`define BIT_QUICK_OVR    0

`define SER_WORD_BITS    16
`define SER_READ_BIT     15
`define SER_ZERO_BIT     14
`define DESKEW_WORD      16'hAAA8
`define PRBS_SEED        15'h7FFF
`define GAIN_UNITY       12'h400
`define GAIN_FRAC_BITS   10
`define REF_DELAY_STEP_PS 60

`endif

// *** core/adc_cfg_pkg.sv ***
// Purpose: Types shared by the configuration and test-pattern block.
// Assumes: Nothing beyond the standard language.
// Notes:   Sample width is fixed at 14 bits in the carrier types.
package adc_cfg_pkg;

  typedef enum logic [3:0] {
    PAT_NORMAL  = 4'h0,
    PAT_ZEROS   = 4'h1,
    PAT_ONES    = 4'h2,
    PAT_TOGGLE  = 4'h3,
    PAT_RAMP    = 4'h4,
    PAT_RSVD5   = 4'h5,
    PAT_SINGLE  = 4'h6,
    PAT_DOUBLE  = 4'h7,
    PAT_DESKEW  = 4'h8,
    PAT_RSVD9   = 4'h9,
    PAT_PRBS    = 4'hA,
    PAT_SINE    = 4'hB
  } pattern_t;

  typedef struct packed {
    logic [13:0] first;
    logic [13:0] second;
  } sample_pair_t;

  typedef struct packed {
    logic [15:0] first;
    logic [15:0] second;
  } link_word_t;

  typedef struct packed {
    logic first;
    logic second;
  } ovr_pair_t;

endpackage

// *** tb/adc_cfg_chk.sv ***
// Purpose: Port-level checker for the configuration and pattern block.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes:   Occupancy is rebuilt from the handshakes, not read from inside.
`timescale 1ns/1ns
`default_nettype none
module adc_cfg_chk #(
  parameter int unsigned BUF_DEPTH = 2
) (
  input wire logic                    clk_i,
  input wire logic                    rstn_i,
  input wire logic                    serial_clk_i,
  input wire logic                    serial_select_n_i,
  input wire logic                    serial_port_out_o,
  input wire logic                    serial_port_out_oe_o,
  input wire logic                    sample_valid_i,
  input wire logic                    sample_ready_o,
  input wire logic                    link_valid_o,
  input wire logic                    link_ready_i,
  input wire adc_cfg_pkg::link_word_t link_word_o,
  input wire adc_cfg_pkg::ovr_pair_t  normal_ovr_i,
  input wire adc_cfg_pkg::ovr_pair_t  quick_ovr_i,
  input wire logic                    first_channel_overrange_out_o,
  input wire logic                    second_channel_overrange_out_o,
  input wire logic [1:0]              sample_clk_div_log2_o,
  input wire logic [2:0]              frame_ref_delay_o,
  input wire logic                    converters_standby_o
);
  logic [3:0] cnt_ff;
  logic [3:0] sclk_ff;
  logic       fell_recent;
  // A synchroniser may delay the read shifter, so three edges are allowed.
  assign fell_recent = |(sclk_ff[3:1] & ~sclk_ff[2:0]);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_ff <= 4'h0;
    else cnt_ff <= cnt_ff + 4'(sample_valid_i && sample_ready_o)
                          - 4'(link_valid_o && link_ready_i);
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) sclk_ff <= 4'h0;
    else sclk_ff <= {sclk_ff[2:0], serial_clk_i};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_buffer_flags: assert property (sample_ready_o == (cnt_ff < BUF_DEPTH)
    && link_valid_o == (cnt_ff != 4'h0)) else $error("buffer flags wrong");
  a_word_held: assert property (link_valid_o && !link_ready_i |=>
    link_valid_o && $stable(link_word_o)) else $error("word not held");
  a_push_visible: assert property (sample_valid_i && sample_ready_o |=>
    link_valid_o) else $error("pushed word not offered");
  a_ovr_routed: assert property (
    (first_channel_overrange_out_o == normal_ovr_i.first &&
     second_channel_overrange_out_o == normal_ovr_i.second) ||
    (first_channel_overrange_out_o == quick_ovr_i.first &&
     second_channel_overrange_out_o == quick_ovr_i.second))
    else $error("overrange outputs mixed");
  a_oe_deselect: assert property (
    serial_select_n_i |-> !serial_port_out_oe_o) else $error("oe idle");
  a_oe_after_rise: assert property (
    $rose(serial_port_out_oe_o) |-> !serial_select_n_i &&
    $past(serial_clk_i)) else $error("oe rose off a rise");
  a_out_steady: assert property (
    serial_port_out_oe_o && $past(serial_port_out_oe_o) && !fell_recent
    |-> $stable(serial_port_out_o)) else $error("read bit moved");
  a_cfg_idle: assert property (
    serial_select_n_i && $past(serial_select_n_i) |->
    $stable({sample_clk_div_log2_o, frame_ref_delay_o,
    converters_standby_o})) else $error("config moved while idle");
  a_div_legal: assert property (
    sample_clk_div_log2_o != 2'h3) else $error("divider code illegal");
  c_full: cover property (sample_valid_i && !sample_ready_o);
  c_stall: cover property (link_valid_o && !link_ready_i);
  c_read: cover property (serial_port_out_oe_o);
endmodule
bind adc_config_and_test_patterns adc_cfg_chk #(.BUF_DEPTH(BUF_DEPTH)) chk_u
  (.*);
`default_nettype wire

// *** tb/serial_host.sv ***
// Purpose: Host controller on the four-wire serial port.
// Assumes: Serial half period of three system clocks.
// Notes:   Read bits are taken just before each rising serial edge.
`timescale 1ns/1ns
`default_nettype none
module serial_host (
  input  wire logic clk_i,
  output var logic  sclk_o,
  output var logic  sel_n_o,
  output var logic  sdi_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    sel_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi_o = w[i];
      repeat (3) @(negedge clk_i);
      if (i < 8) rd[i] = sdo_oe_i ? sdo_i : 1'bx;
      sclk_o = 1'b1;
      repeat (3) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (3) @(negedge clk_i);
    sel_n_o = 1'b1;
    // The data line is not meaningful now, so it is kept moving.
    sdi_o = ~sdi_o;
    repeat (3) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** tb/test_adc_config_and_test_patterns.sv ***
// Purpose: Self-checking bench for the configuration and pattern block.
// Assumes: Pattern state advances once per accepted sample pair.
// Notes:   Each pattern run starts from a soft reset for a known state.
`timescale 1ns/1ns
`default_nettype none
module test_adc_config_and_test_patterns;
  import adc_cfg_pkg::*;
  logic clk_i, rstn_i, serial_clk_i, serial_select_n_i, serial_port_in_i;
  logic serial_port_out_o, serial_port_out_oe_o, sample_valid_i;
  logic sample_ready_o, link_valid_o, link_ready_i, converters_standby_o;
  logic first_channel_overrange_out_o, second_channel_overrange_out_o;
  logic power_down_first_channel_o, power_down_second_channel_o;
  logic [1:0] sample_clk_div_log2_o, high_input_mode_first_o;
  logic [1:0] high_input_mode_second_o;
  logic [2:0] frame_ref_delay_o;
  sample_pair_t sample_i;
  link_word_t link_word_o;
  ovr_pair_t normal_ovr_i, quick_ovr_i;
  int fails, comparisons, n, run, k, c;
  logic [7:0] d, r;
  logic [15:0] c1, c2;
  logic [3:0] pa, pb;
  logic fmt;
  logic [14:0] lfsr;
  logic [31:0] w;
  logic [31:0] q[$];
  int sine[8] = '{0, 2399, 8192, 13984, 16383, 13984, 8192, 2399};
  logic [5:0] ofs[12] = '{6'h06, 6'h07, 6'h08, 6'h0B, 6'h0C, 6'h0D, 6'h0E,
                          6'h0F, 6'h10, 6'h11, 6'h12, 6'h13};
  logic [7:0] msk[12] = '{8'h03, 8'h07, 8'hF8, 8'hFC, 8'hFC, 8'h91, 8'h90,
                          8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  adc_config_and_test_patterns dut_u (.*);
  serial_host host_u (.clk_i(clk_i), .sclk_o(serial_clk_i),
    .sel_n_o(serial_select_n_i), .sdi_o(serial_port_in_i),
    .sdo_i(serial_port_out_o), .sdo_oe_i(serial_port_out_oe_o));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    logic [7:0] x;
    host_u.xfer({2'b00, a, v}, x);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    host_u.xfer({2'b10, a, 8'h00}, v);
  endtask
  task automatic zeros;
    logic [7:0] v;
    for (int j = 0; j < 13; j++) begin
      rd(j < 12 ? ofs[j] : 6'h20, v);
      chk_reg(v, 8'h00);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] pat(input logic [3:0] p,
                                      input logic [13:0] s);
    case (p)
      4'h0: return {s ^ {fmt, 13'h0000}, 2'b00};
      4'h2: return 16'hFFFC;
      4'h3: return n[0] ? 16'h5554 : 16'hAAA8;
      4'h4: return {n[15:2], 2'b00};
      4'h6: return c1 & 16'hFFFC;
      4'h7: return (n[0] ? c2 : c1) & 16'hFFFC;
      4'h8: return 16'hAAA8;
      4'hA: return {lfsr[13:0], 2'b00};
      4'hB: return {sine[n % 8][13:0], 2'b00};
      default: return 16'h0000;
    endcase
  endfunction
  always @(negedge clk_i) begin
    sample_valid_i <= run != 0 && $urandom_range(3) != 0;
    sample_i <= 28'($urandom);
    link_ready_i <= $urandom_range(1) != 0;
    normal_ovr_i <= 2'($urandom);
    quick_ovr_i <= 2'($urandom);
  end
  always @(posedge clk_i) begin
    if (rstn_i && sample_valid_i && sample_ready_o) begin
      q.push_back({pat(pa, sample_i.first), pat(pb, sample_i.second)});
      lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
      n++;
    end
    if (rstn_i && link_valid_o && link_ready_i) begin
      w = (q.size() != 0) ? q.pop_front() : 'x;
      chk_word(link_word_o, w);
    end
  end
  initial begin
    #2_400_000;
    fails++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'hbe5b));
    {rstn_i, pa, pb, fmt} = '0;
    repeat (5) @(negedge clk_i);
    rstn_i = 1'b1;
    zeros();
    for (k = 0; k < 12; k++) begin
      d = 8'($urandom);
      if (k == 2) d = (d & 8'hFE) | 8'h08;
      if (k > 4 && k < 7) d[4] = d[7];
      wr(ofs[k], d);
      rd(ofs[k], r);
      chk_reg(r, d & msk[k]);
    end
    host_u.xfer({2'b01, 6'h13, ~d}, r);
    rd(6'h13, r);
    chk_reg(r, d);
    for (k = 0; k < 4; k++) begin
      wr(6'h06, 8'(k));
      chk_reg({6'h00, sample_clk_div_log2_o},
              (k == 3) ? 8'h02 : {7'h00, k == 1});
    end
    wr(6'h07, 8'hFD);
    chk_reg({5'h00, frame_ref_delay_o}, 8'h05);
    for (k = 0; k < 2; k++) begin
      d = (k != 0) ? 8'h48 : 8'hA8;
      wr(6'h08, d);
      chk_reg({5'h00, power_down_first_channel_o, power_down_second_channel_o,
               converters_standby_o}, {5'h00, d[7:5]});
    end
    for (k = 0; k < 2; k++) begin
      wr(6'h0D, (k != 0) ? 8'h00 : 8'h91);
      wr(6'h0E, (k != 0) ? 8'h00 : 8'h90);
      chk_reg({4'h0, high_input_mode_first_o, high_input_mode_second_o},
              (k != 0) ? 8'h00 : 8'h0F);
      repeat (4) begin
        @(posedge clk_i);
        chk_reg({6'h00, first_channel_overrange_out_o,
                 second_channel_overrange_out_o},
                {6'h00, (k != 0) ? normal_ovr_i : quick_ovr_i});
      end
    end
    wr(6'h08, 8'h09);
    zeros();
    for (c = 0; c < 12; c++) begin
      wr(6'h08, 8'h09);
      c1 = 16'($urandom);
      c2 = 16'($urandom);
      wr(6'h10, c1[15:8]);
      wr(6'h11, c1[7:0]);
      wr(6'h12, c2[15:8]);
      wr(6'h13, c2[7:0]);
      fmt = c[0];
      wr(6'h08, {3'b000, fmt, 4'h8});
      wr(6'h0B, {5'($urandom), 3'b000});
      pa = 4'(c);
      pb = 4'(11 - c);
      wr(6'h0F, {pa, pb});
      n = 0;
      lfsr = 15'h7FFF;
      run = 1;
      repeat (60) @(negedge clk_i);
      run = 0;
      repeat (30) @(negedge clk_i);
      chk_reg(8'(q.size()), 8'h00);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
